//--- ict_pkg.sv
package ict_pkg;

  // bus cycle kinds shown on each memory bus
  typedef enum logic [2:0]
  {
    cyc_none = 3'h0,
    cyc_n    = 3'h1,
    cyc_s    = 3'h2,
    cyc_i    = 3'h3,
    cyc_c    = 3'h4
  } ict_cyc_type;

  // instruction classes
  typedef enum logic [3:0]
  {
    op_data_op        = 4'h0,
    op_single_load    = 4'h1,
    op_single_store   = 4'h2,
    op_block_load     = 4'h3,
    op_block_store    = 4'h4,
    op_atomic_swap    = 4'h5,
    op_branch         = 4'h6,
    op_copro_data_op  = 4'h7,
    op_copro_xfer     = 4'h8,
    op_core_to_copro  = 4'h9,
    op_copro_to_core  = 4'ha,
    op_status_read    = 4'hb,
    op_status_write   = 4'hc,
    op_multiply       = 4'hd,
    op_long_multiply  = 4'he
  } ict_op_type;

  localparam int CNT_W  = 6;
  localparam int NREG_W = 5;

  // early termination boundaries of the multiplier operand
  localparam int M_LSB1 = 8;
  localparam int M_LSB2 = 16;
  localparam int M_LSB3 = 24;

  // fixed cycle figures
  localparam int PC_TAIL_I    = 4;
  localparam int PC_REFILL_S  = 2;
  localparam int MUL_BASE     = 2;
  localparam int LMUL_BASE    = 3;
  localparam int STATUS_SLOW  = 3;

  typedef struct packed
  {
    ict_op_type        op;
    logic              pc_dest;
    logic              reg_shift;
    logic              next_uses;
    logic              narrow;
    logic              flags_only;
    logic              signed_mul;
    logic [NREG_W-1:0] nregs;
    logic [31:0]       mul_operand;
  } ict_desc_type;

  typedef struct packed
  {
    ict_cyc_type      typ;
    logic [CNT_W-1:0] cnt;
  } ict_seg_type;

  typedef struct packed
  {
    ict_seg_type [2:0] seg;
  } ict_plan_type;

  typedef struct packed
  {
    ict_cyc_type ibus;
    ict_cyc_type dbus;
  } ict_bus_type;

  localparam ict_plan_type PLAN_RESET = '0;
  localparam ict_bus_type  BUS_RESET  = '{ibus: cyc_none, dbus: cyc_none};

endpackage

//--- ict_core.sv
`timescale 1ns/1ns

// What this block does
// RULE1: plain data op: one cycle, S fetch, I data.
// RULE2: register shift data op: two cycles, S then I fetch.
// RULE3: data op writing pc: 2S+1N, plus 1I with register shift.
// RULE4: single load, result unused next: one cycle, S fetch, N data.
// RULE5: word used next: one interlock cycle, I on both buses.
// RULE6: byte, halfword or unaligned used next: two interlock cycles.
// RULE7: single load to pc: five cycles, 2S+2I+1N fetch, 1N+4I data.
// RULE8: block load of one register: 1S+1I on both buses.
// RULE9: block load of n registers: n cycles, data 1N then (n-1)S.
// RULE10: block load with pc: n+4 cycles, data ends in four I cycles.
// RULE11: block store: one register 1N+1I, else 1N+(n-1)S data.
// RULE12: swap: two N data cycles, extra I when the result is used next.
// RULE13: copro to core move: b+1, b+2 when used, b+3 to pc.
// RULE14: status write of flags only: one cycle, one S fetch.
// RULE15: other status writes: three cycles, 1S+2I fetch.
// RULE16: multiply 2+m cycles, long forms 3+m, data all I.
// RULE17: coprocessor busy-wait adds b cycles; data op b+1, transfers b+n.
// RULE18: core-coprocessor register moves show b I, plus the RULE13 internal cycles, then one C cycle.
// RULE19: fetches halt while an interlock holds the pipeline.
// RULE20: m from sign extension (zero extension when unsigned) of operand bits 31:8, 31:16, 31:24.
// RULE21: branches, swi, undefined take 2S+1N; single store one cycle.
module ict_core
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // instruction issue
  input  wire logic                  issue_valid,
  input  wire ict_pkg::ict_desc_type issue_desc,
  output logic                       issue_ready,
  // coprocessor handshake
  input  wire logic                  copro_busy,
  // bus activity
  output ict_pkg::ict_bus_type       bus_cycle,
  output logic                       fetch_active,
  output logic                       last_cycle
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0]
  {
    st_idle = 3'b001,
    st_wait = 3'b010,
    st_run  = 3'b100
  } ict_state_type;

  ict_state_type         state_reg;
  ict_state_type         state_next;
  ict_pkg::ict_plan_type ip_reg;
  ict_pkg::ict_plan_type ip_next;
  ict_pkg::ict_plan_type dp_reg;
  ict_pkg::ict_plan_type dp_next;
  ict_pkg::ict_bus_type  bus_reg;
  ict_pkg::ict_bus_type  bus_next;
  logic                  last_reg;
  logic                  last_next;

  ////////////////////////////////////////////////////////////////////////////
  function automatic ict_pkg::ict_plan_type mk(ict_pkg::ict_cyc_type t0, int c0,
                                               ict_pkg::ict_cyc_type t1, int c1,
                                               ict_pkg::ict_cyc_type t2, int c2);
    ict_pkg::ict_plan_type p;
    p.seg[0].typ = t0;
    p.seg[0].cnt = ict_pkg::CNT_W'(c0);
    p.seg[1].typ = t1;
    p.seg[1].cnt = ict_pkg::CNT_W'(c1);
    p.seg[2].typ = t2;
    p.seg[2].cnt = ict_pkg::CNT_W'(c2);
    return p;
  endfunction
  // RULE20: early termination count
  function automatic int mul_m(logic [31:0] x, logic sgn);
    logic e1;
    logic e2;
    logic e3;
    e1 = ~|x[31:ict_pkg::M_LSB1] | (sgn & (&x[31:ict_pkg::M_LSB1]));
    e2 = ~|x[31:ict_pkg::M_LSB2] | (sgn & (&x[31:ict_pkg::M_LSB2]));
    e3 = ~|x[31:ict_pkg::M_LSB3] | (sgn & (&x[31:ict_pkg::M_LSB3]));
    return e1 ? 1 : (e2 ? 2 : (e3 ? 3 : 4));
  endfunction
  function automatic logic is_copro(ict_pkg::ict_op_type op);
    return (op == ict_pkg::op_copro_data_op) || (op == ict_pkg::op_copro_xfer) ||
           (op == ict_pkg::op_core_to_copro) || (op == ict_pkg::op_copro_to_core);
  endfunction
  // lowest non-empty segment gives this cycle's kind
  function automatic ict_pkg::ict_cyc_type front(ict_pkg::ict_plan_type p);
    for (int k = 0; k < 3; k++)
      if (p.seg[k].cnt != '0)
        return p.seg[k].typ;
    return ict_pkg::cyc_none;
  endfunction
  function automatic ict_pkg::ict_plan_type pop(ict_pkg::ict_plan_type p);
    ict_pkg::ict_plan_type q;
    logic                  hit;
    q = p;
    hit = 1'b0;
    for (int k = 0; k < 3; k++)
      if (!hit && p.seg[k].cnt != '0)
      begin
        q.seg[k].cnt = p.seg[k].cnt - 1'b1;
        hit = 1'b1;
      end
    return q;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // plans for instruction bus and data bus; copro busy cycles come on top
  ict_pkg::ict_plan_type dec_ip;
  ict_pkg::ict_plan_type dec_dp;
  always_comb
  begin
    int n;
    int m;
    n = int'(issue_desc.nregs);
    // empty register list counts as one word, so no count wraps
    if (n == 0)
      n = 1;
    m = mul_m(issue_desc.mul_operand, issue_desc.signed_mul);
    dec_ip = ict_pkg::PLAN_RESET;
    dec_dp = ict_pkg::PLAN_RESET;
    unique case (issue_desc.op)
      ict_pkg::op_data_op:
      begin
        // RULE3: pc write refills the pipe
        if (issue_desc.pc_dest)
        begin
          dec_ip = mk(ict_pkg::cyc_s, ict_pkg::PC_REFILL_S, ict_pkg::cyc_n, 1,
                      ict_pkg::cyc_i, issue_desc.reg_shift ? 1 : 0);
          dec_dp = mk(ict_pkg::cyc_i, issue_desc.reg_shift ? 4 : 3,
                      ict_pkg::cyc_none, 0, ict_pkg::cyc_none, 0);
        end
        else
        begin
          // RULE1: single cycle
          // RULE2: shift by register adds one I
          dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i, issue_desc.reg_shift ? 1 : 0,
                      ict_pkg::cyc_none, 0);
          dec_dp = mk(ict_pkg::cyc_i, issue_desc.reg_shift ? 2 : 1,
                      ict_pkg::cyc_none, 0, ict_pkg::cyc_none, 0);
        end
      end
      ict_pkg::op_single_load:
      begin
        if (issue_desc.pc_dest)
        begin
          // RULE7: load to pc
          dec_ip = mk(ict_pkg::cyc_s, ict_pkg::PC_REFILL_S, ict_pkg::cyc_i, 2,
                      ict_pkg::cyc_n, 1);
          dec_dp = mk(ict_pkg::cyc_n, 1, ict_pkg::cyc_i, ict_pkg::PC_TAIL_I,
                      ict_pkg::cyc_none, 0);
        end
        else
        begin
          // RULE4: plain load
          // RULE5: word load-use interlock
          // RULE6: narrow load-use, two interlock cycles
          dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i,
                      issue_desc.next_uses ? (issue_desc.narrow ? 2 : 1) : 0,
                      ict_pkg::cyc_none, 0);
          dec_dp = mk(ict_pkg::cyc_n, 1, ict_pkg::cyc_i,
                      issue_desc.next_uses ? (issue_desc.narrow ? 2 : 1) : 0,
                      ict_pkg::cyc_none, 0);
        end
      end
      ict_pkg::op_block_load:
      begin
        if (issue_desc.pc_dest)
        begin
          // RULE10: n+4 cycles, four I cycles close the data side
          dec_ip = mk(ict_pkg::cyc_s, ict_pkg::PC_REFILL_S, ict_pkg::cyc_n, 1,
                      ict_pkg::cyc_i, n + 1);
          dec_dp = mk(ict_pkg::cyc_n, 1, ict_pkg::cyc_s, n - 1,
                      ict_pkg::cyc_i, ict_pkg::PC_TAIL_I);
        end
        else if (n <= 1)
        begin
          // RULE8: one register
          dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i, 1, ict_pkg::cyc_none, 0);
          dec_dp = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i, 1, ict_pkg::cyc_none, 0);
        end
        else
        begin
          // RULE9: n transfers, burst after one N
          dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i, n - 1, ict_pkg::cyc_none, 0);
          dec_dp = mk(ict_pkg::cyc_n, 1, ict_pkg::cyc_s, n - 1, ict_pkg::cyc_none, 0);
        end
      end
      ict_pkg::op_block_store:
      begin
        // RULE11: single register adds an I, else a burst
        dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i, (n <= 1) ? 1 : n - 1,
                    ict_pkg::cyc_none, 0);
        dec_dp = (n <= 1) ?
                 mk(ict_pkg::cyc_n, 1, ict_pkg::cyc_i, 1, ict_pkg::cyc_none, 0) :
                 mk(ict_pkg::cyc_n, 1, ict_pkg::cyc_s, n - 1, ict_pkg::cyc_none, 0);
      end
      ict_pkg::op_atomic_swap:
      begin
        // RULE12: read then write, both N
        dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i, issue_desc.next_uses ? 2 : 1,
                    ict_pkg::cyc_none, 0);
        dec_dp = mk(ict_pkg::cyc_n, 2, ict_pkg::cyc_i, issue_desc.next_uses ? 1 : 0,
                    ict_pkg::cyc_none, 0);
      end
      ict_pkg::op_branch:
      begin
        // RULE21: branch class refills the pipe
        dec_ip = mk(ict_pkg::cyc_s, ict_pkg::PC_REFILL_S, ict_pkg::cyc_n, 1,
                    ict_pkg::cyc_none, 0);
        dec_dp = mk(ict_pkg::cyc_i, 3, ict_pkg::cyc_none, 0, ict_pkg::cyc_none, 0);
      end
      ict_pkg::op_copro_data_op:
      begin
        // RULE17: b+1 with busy cycles added in st_wait
        dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_none, 0, ict_pkg::cyc_none, 0);
        dec_dp = mk(ict_pkg::cyc_i, 1, ict_pkg::cyc_none, 0, ict_pkg::cyc_none, 0);
      end
      ict_pkg::op_copro_xfer:
      begin
        // RULE17: b+n for copro load and store
        dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i, n - 1, ict_pkg::cyc_none, 0);
        dec_dp = mk(ict_pkg::cyc_n, 1, ict_pkg::cyc_s, n - 1, ict_pkg::cyc_none, 0);
      end
      ict_pkg::op_core_to_copro,
      ict_pkg::op_copro_to_core:
      begin
        // RULE13: use or pc target adds internal cycles
        // RULE18: transfer is one C cycle after the I cycles
        m = 0;
        if (issue_desc.op == ict_pkg::op_copro_to_core)
          m = issue_desc.pc_dest ? 2 : (issue_desc.next_uses ? 1 : 0);
        dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i, m, ict_pkg::cyc_none, 0);
        dec_dp = mk(ict_pkg::cyc_i, m, ict_pkg::cyc_c, 1, ict_pkg::cyc_none, 0);
      end
      ict_pkg::op_status_write:
      begin
        // RULE14: flags only, one cycle
        // RULE15: other fields, three cycles
        dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i,
                    issue_desc.flags_only ? 0 : ict_pkg::STATUS_SLOW - 1,
                    ict_pkg::cyc_none, 0);
        dec_dp = mk(ict_pkg::cyc_i, issue_desc.flags_only ? 1 : ict_pkg::STATUS_SLOW,
                    ict_pkg::cyc_none, 0, ict_pkg::cyc_none, 0);
      end
      ict_pkg::op_multiply,
      ict_pkg::op_long_multiply:
      begin
        // RULE16: 2+m or 3+m, data bus idle throughout
        n = (issue_desc.op == ict_pkg::op_long_multiply) ? ict_pkg::LMUL_BASE
                                                         : ict_pkg::MUL_BASE;
        dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_i, n + m - 1, ict_pkg::cyc_none, 0);
        dec_dp = mk(ict_pkg::cyc_i, n + m, ict_pkg::cyc_none, 0, ict_pkg::cyc_none, 0);
      end
      default:
      begin
        // RULE21: single store and status read, one cycle
        dec_ip = mk(ict_pkg::cyc_s, 1, ict_pkg::cyc_none, 0, ict_pkg::cyc_none, 0);
        dec_dp = mk((issue_desc.op == ict_pkg::op_single_store) ? ict_pkg::cyc_n
                                                                : ict_pkg::cyc_i,
                    1, ict_pkg::cyc_none, 0, ict_pkg::cyc_none, 0);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer; one pop per cycle keeps both buses in step
  ict_pkg::ict_plan_type src_ip;
  ict_pkg::ict_plan_type src_dp;
  ict_pkg::ict_plan_type rem_ip;
  ict_pkg::ict_plan_type rem_dp;
  logic                  accept;
  logic                  waiting;
  assign issue_ready = (state_reg == st_idle);
  assign accept      = issue_ready && issue_valid;
  assign src_ip      = accept ? dec_ip : ip_reg;
  assign src_dp      = accept ? dec_dp : dp_reg;
  assign waiting     = (accept && is_copro(issue_desc.op)) || (state_reg == st_wait);
  assign rem_ip      = pop(src_ip);
  assign rem_dp      = pop(src_dp);
  always_comb
  begin
    state_next = state_reg;
    ip_next    = ip_reg;
    dp_next    = dp_reg;
    bus_next   = ict_pkg::BUS_RESET;
    last_next  = 1'b0;
    // RULE17: busy-wait stretches with I cycles on both buses
    if (waiting && copro_busy)
    begin
      state_next    = st_wait;
      ip_next       = src_ip;
      dp_next       = src_dp;
      bus_next.ibus = ict_pkg::cyc_i;
      bus_next.dbus = ict_pkg::cyc_i;
    end
    else if (accept || state_reg != st_idle)
    begin
      bus_next.ibus = front(src_ip);
      bus_next.dbus = front(src_dp);
      ip_next       = rem_ip;
      dp_next       = rem_dp;
      state_next    = st_run;
      if (front(rem_ip) == ict_pkg::cyc_none && front(rem_dp) == ict_pkg::cyc_none)
      begin
        state_next = st_idle;
        last_next  = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= st_idle;
      ip_reg    <= ict_pkg::PLAN_RESET;
      dp_reg    <= ict_pkg::PLAN_RESET;
      bus_reg   <= ict_pkg::BUS_RESET;
      last_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ip_reg    <= ip_next;
      dp_reg    <= dp_next;
      bus_reg   <= bus_next;
      last_reg  <= last_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign bus_cycle  = bus_reg;
  assign last_cycle = last_reg;
  // RULE19: interlock and internal cycles stop fetching
  assign fetch_active = (bus_reg.ibus == ict_pkg::cyc_s) || (bus_reg.ibus == ict_pkg::cyc_n);
endmodule // ict_core

//--- ict_timing_props.sv
`timescale 1ns/1ns
module ict_timing_props
(
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  // instruction issue
  input wire logic                  issue_valid,
  input wire ict_pkg::ict_desc_type issue_desc,
  input wire logic                  issue_ready,
  input wire logic                  copro_busy,
  // bus activity
  input wire ict_pkg::ict_bus_type  bus_cycle,
  input wire logic                  fetch_active,
  input wire logic                  last_cycle
);
  logic        take;
  logic        ld;
  logic        is_s;
  logic [31:0] opnd;
  assign take = issue_valid && issue_ready;
  assign ld   = take && issue_desc.op == ict_pkg::op_single_load;
  assign is_s = bus_cycle.ibus == ict_pkg::cyc_s;
  assign opnd = issue_desc.mul_operand;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_fetch_tracks_ibus: assert property
    (fetch_active == (is_s || bus_cycle.ibus == ict_pkg::cyc_n))
    else $error("fetch indicator disagrees with ibus code");
  a_idle_bus_none: assert property
    (issue_ready && !last_cycle |-> bus_cycle == ict_pkg::BUS_RESET)
    else $error("bus code shown while idle");
  a_ready_at_last: assert property
    (last_cycle |-> issue_ready)
    else $error("not ready in last cycle");
  a_plain_op_one: assert property
    (take && issue_desc.op == ict_pkg::op_data_op && !issue_desc.pc_dest && !issue_desc.reg_shift
      |=> last_cycle && is_s && bus_cycle.dbus == ict_pkg::cyc_i)
    else $error("plain data op not one S/I cycle");
  a_shift_op_two: assert property
    (take && issue_desc.op == ict_pkg::op_data_op && !issue_desc.pc_dest && issue_desc.reg_shift
      |=> !last_cycle ##1 last_cycle)
    else $error("shifted data op not two cycles");
  a_word_use_stall: assert property
    (ld && !issue_desc.pc_dest && issue_desc.next_uses && !issue_desc.narrow
      |=> (is_s && bus_cycle.dbus == ict_pkg::cyc_n)
      ##1 (last_cycle && !fetch_active && bus_cycle.dbus == ict_pkg::cyc_i))
    else $error("word load interlock wrong");
  a_narrow_stall: assert property
    (ld && !issue_desc.pc_dest && issue_desc.next_uses && issue_desc.narrow
      |=> !last_cycle ##1 (!fetch_active && !last_cycle) ##1 (!fetch_active && last_cycle))
    else $error("narrow load interlock wrong");
  a_pc_load_five: assert property
    (ld && issue_desc.pc_dest |=> !last_cycle [*4] ##1 last_cycle)
    else $error("load to pc not five cycles");
  a_flags_write_one: assert property
    (take && issue_desc.op == ict_pkg::op_status_write && issue_desc.flags_only
      |=> last_cycle && is_s)
    else $error("flags write not one cycle");
  a_status_slow: assert property
    (take && issue_desc.op == ict_pkg::op_status_write && !issue_desc.flags_only
      |=> !last_cycle [*2] ##1 last_cycle)
    else $error("status write not three cycles");
  a_short_multiply: assert property
    (take && issue_desc.op == ict_pkg::op_multiply && issue_desc.signed_mul
      && (&opnd[31:8] || ~|opnd[31:8]) |=> !last_cycle [*2] ##1 last_cycle)
    else $error("multiply with m of one not three cycles");
  a_copro_move_c: assert property
    (take && issue_desc.op == ict_pkg::op_copro_to_core && !issue_desc.pc_dest
      && !issue_desc.next_uses && !copro_busy
      |=> last_cycle && bus_cycle.dbus == ict_pkg::cyc_c)
    else $error("register move not one C cycle");
endmodule // ict_timing_props

bind ict_core ict_timing_props u_props (.sys_clk, .rst_n, .issue_valid, .issue_desc,
  .issue_ready, .copro_busy, .bus_cycle, .fetch_active, .last_cycle);

//--- ict_copro_model.sv
`timescale 1ns/1ns
module ict_copro_model
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // start of a coprocessor instruction and its wait length
  input wire logic       start,
  input wire logic [3:0] wait_cycles,
  // busy-wait level to the core
  output logic           copro_busy
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  always_comb
  begin
    cnt_next = cnt_reg;
    if (start && wait_cycles != 4'h0)
      cnt_next = wait_cycles - 4'h1;
    else if (cnt_reg != 4'h0)
      cnt_next = cnt_reg - 4'h1;
  end
  // busy already high on the take edge, so b counts from there
  assign copro_busy = start ? (wait_cycles != 4'h0) : (cnt_reg != 4'h0);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_next;
  end
endmodule // ict_copro_model

//--- ict_core_bench.sv
`timescale 1ns/1ns
module ict_core_bench;
  logic                  sys_clk     = 1'b0;
  logic                  rst_n       = 1'b0;
  logic                  issue_valid = 1'b0;
  ict_pkg::ict_desc_type issue_desc  = '0;
  logic                  cp_load     = 1'b0;
  logic [3:0]            cp_b        = 4'h0;
  logic                  issue_ready;
  logic                  copro_busy;
  logic                  fetch_active;
  logic                  last_cycle;
  ict_pkg::ict_bus_type  bus_cycle;
  int                    n_mismatch  = 0;
  int                    tests_run   = 0;
  int                    cycles      = 0;

  always #10 sys_clk = ~sys_clk;

  ict_core dut (.sys_clk, .rst_n, .issue_valid, .issue_desc, .issue_ready, .copro_busy,
    .bus_cycle, .fetch_active, .last_cycle);
  ict_copro_model u_copro (.sys_clk, .rst_n, .start(cp_load), .wait_cycles(cp_b), .copro_busy);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard, whole run needs under two hundred cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  function automatic string code(ict_pkg::ict_cyc_type c);
    case (c)
      ict_pkg::cyc_n: return "N";
      ict_pkg::cyc_s: return "S";
      ict_pkg::cyc_i: return "I";
      ict_pkg::cyc_c: return "C";
      ict_pkg::cyc_none: return "-";
      default: return "X";
    endcase
  endfunction

  function automatic string flag(logic b);
    return (b === 1'b1) ? "F" : "-";
  endfunction

  // order inside a sequence is left open, so codes are compared as a multiset
  function automatic string srt(string s);
    string keys;
    string r;
    keys = "-CFINSX";
    r = "";
    for (int j = 0; j < keys.len(); j++)
      for (int k = 0; k < s.len(); k++)
        if (s[k] == keys[j])
          r = {r, keys.substr(j, j)};
    return r;
  endfunction

  task automatic cmp_str(string name, string exp, string got);
    tests_run++;
    if (exp != got)
    begin
      n_mismatch++;
      $display("mismatch %s expected %s seen %s", name, exp, got);
    end
  endtask

  task automatic cmp_bit(string name, logic exp, logic got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  // issue one instruction at an edge and collect its bus codes
  task automatic run(ict_pkg::ict_op_type op, logic [5:0] f, logic [4:0] n, logic [31:0] v,
    logic [3:0] b, string ei, string ed);
    string gi;
    string gd;
    string gf;
    string ef;
    gi = "";
    gd = "";
    gf = "";
    ef = "";
    // fetching only on S and N instruction cycles
    for (int k = 0; k < ei.len(); k++)
      ef = {ef, flag(ei[k] == "S" || ei[k] == "N")};
    issue_valid <= 1'b1;
    issue_desc  <= ict_pkg::ict_desc_type'({op, f, n, v});
    cp_load     <= 1'b1;
    cp_b        <= b;
    @(posedge sys_clk);
    issue_valid <= 1'b0;
    cp_load     <= 1'b0;
    for (int k = 0; k < 40; k++)
    begin
      @(negedge sys_clk);
      gi = {gi, code(bus_cycle.ibus)};
      gd = {gd, code(bus_cycle.dbus)};
      gf = {gf, flag(fetch_active)};
      if (last_cycle === 1'b1)
        break;
    end
    cmp_bit("ready in last cycle", 1'b1, issue_ready);
    @(posedge sys_clk);
    cmp_str("ibus codes", srt(ei), srt(gi));
    cmp_str("dbus codes", srt(ed), srt(gd));
    cmp_str("fetch cycles", srt(ef), srt(gf));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // flag bits: pc_dest 20, reg_shift 10, next_uses 08, narrow 04, flags_only 02, signed 01
  task automatic t_data_ops();
    run(ict_pkg::op_data_op, 6'h00, 5'h00, 32'h0, 4'h0, "S", "I");
    run(ict_pkg::op_data_op, 6'h10, 5'h00, 32'h0, 4'h0, "SI", "II");
    run(ict_pkg::op_data_op, 6'h20, 5'h00, 32'h0, 4'h0, "SSN", "III");
    run(ict_pkg::op_data_op, 6'h30, 5'h00, 32'h0, 4'h0, "SSNI", "IIII");
  endtask

  task automatic t_loads();
    run(ict_pkg::op_single_load, 6'h00, 5'h00, 32'h0, 4'h0, "S", "N");
    run(ict_pkg::op_single_load, 6'h08, 5'h00, 32'h0, 4'h0, "SI", "NI");
    run(ict_pkg::op_single_load, 6'h0c, 5'h00, 32'h0, 4'h0, "SII", "NII");
    run(ict_pkg::op_single_load, 6'h20, 5'h00, 32'h0, 4'h0, "SSIIN", "NIIII");
    run(ict_pkg::op_single_store, 6'h00, 5'h00, 32'h0, 4'h0, "S", "N");
  endtask

  task automatic t_blocks();
    run(ict_pkg::op_block_load, 6'h00, 5'h01, 32'h0, 4'h0, "SI", "SI");
    run(ict_pkg::op_block_load, 6'h00, 5'h04, 32'h0, 4'h0, "SIII", "NSSS");
    run(ict_pkg::op_block_load, 6'h20, 5'h03, 32'h0, 4'h0, "SSNIIII", "NSSIIII");
    run(ict_pkg::op_block_store, 6'h00, 5'h01, 32'h0, 4'h0, "SI", "NI");
    run(ict_pkg::op_block_store, 6'h00, 5'h03, 32'h0, 4'h0, "SII", "NSS");
  endtask

  task automatic t_swap();
    run(ict_pkg::op_atomic_swap, 6'h00, 5'h00, 32'h0, 4'h0, "SI", "NN");
    run(ict_pkg::op_atomic_swap, 6'h0c, 5'h00, 32'h0, 4'h0, "SII", "NNI");
  endtask

  task automatic t_copro();
    run(ict_pkg::op_copro_data_op, 6'h00, 5'h00, 32'h0, 4'h2, "SII", "III");
    run(ict_pkg::op_copro_xfer, 6'h00, 5'h03, 32'h0, 4'h1, "SIII", "INSS");
    run(ict_pkg::op_core_to_copro, 6'h00, 5'h00, 32'h0, 4'h3, "SIII", "IIIC");
    run(ict_pkg::op_copro_to_core, 6'h00, 5'h00, 32'h0, 4'h0, "S", "C");
    run(ict_pkg::op_copro_to_core, 6'h08, 5'h00, 32'h0, 4'h2, "SIII", "IIIC");
    run(ict_pkg::op_copro_to_core, 6'h28, 5'h00, 32'h0, 4'h1, "SIII", "IIIC");
  endtask

  task automatic t_status();
    run(ict_pkg::op_status_write, 6'h02, 5'h00, 32'h0, 4'h0, "S", "I");
    run(ict_pkg::op_status_write, 6'h00, 5'h00, 32'h0, 4'h0, "SII", "III");
    run(ict_pkg::op_status_read, 6'h00, 5'h00, 32'h0, 4'h0, "S", "I");
  endtask

  // signed ffffff80 gives m of one, unsigned fffffff0 gives m of four
  task automatic t_multiply();
    run(ict_pkg::op_multiply, 6'h01, 5'h00, 32'hffffff80, 4'h0, "SII", "III");
    run(ict_pkg::op_multiply, 6'h00, 5'h00, 32'h00001234, 4'h0, "SIII", "IIII");
    run(ict_pkg::op_long_multiply, 6'h01, 5'h00, 32'h00ff0000, 4'h0, "SIIIII", "IIIIII");
    run(ict_pkg::op_long_multiply, 6'h00, 5'h00, 32'hfffffff0, 4'h0, "SIIIIII", "IIIIIII");
  endtask

  task automatic t_branch();
    run(ict_pkg::op_branch, 6'h00, 5'h00, 32'h0, 4'h0, "SSN", "III");
  endtask

  // reset in the middle of a five cycle load
  task automatic t_reset();
    issue_valid <= 1'b1;
    issue_desc  <= ict_pkg::ict_desc_type'({ict_pkg::op_single_load, 6'h20, 5'h00, 32'h0});
    @(posedge sys_clk);
    issue_valid <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(negedge sys_clk);
    cmp_str("ibus in reset", "-", code(bus_cycle.ibus));
    cmp_bit("ready in reset", 1'b1, issue_ready);
    cmp_bit("last in reset", 1'b0, last_cycle);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    run(ict_pkg::op_data_op, 6'h00, 5'h00, 32'h0, 4'h0, "S", "I");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_data_ops();
    t_loads();
    t_blocks();
    t_swap();
    t_copro();
    t_status();
    t_multiply();
    t_branch();
    t_reset();
    stop_test();
  end
endmodule // ict_core_bench
